// ==== common/wtc_pkg.sv ====
// wtc_pkg: constants shared by the wake timer control block.
// assumes a crystal-rate reference clock and an 8-bit register port.
package wtc_pkg;
    // register addresses on the parallel register port
    localparam logic [5:0] WTC_ADDR_FIRST_HI = 6'h1E;
    localparam logic [5:0] WTC_ADDR_FIRST_LO = 6'h1F;
    localparam logic [5:0] WTC_ADDR_CTRL = 6'h20;
    // control register fields
    localparam int WTC_PD_BIT = 7;
    localparam int WTC_SEL_HI = 6;
    localparam int WTC_SEL_LO = 4;
    localparam int WTC_CAL_BIT = 3;
    localparam int WTC_RES_HI = 1;
    localparam int WTC_RES_LO = 0;
    // reset values
    localparam logic [7:0] WTC_FIRST_HI_RST = 8'h87;
    localparam logic [7:0] WTC_FIRST_LO_RST = 8'h6B;
    localparam logic WTC_PD_RST = 1'b1;
    localparam logic [2:0] WTC_SEL_RST = 3'h7;
    localparam logic WTC_CAL_RST = 1'b1;
    localparam logic [1:0] WTC_RES_RST = 2'h0;
    // slow oscillator period in crystal cycles
    localparam int WTC_SLOW_DIV = 750;
    localparam logic [9:0] WTC_SLOW_DIV_LAST = 10'(WTC_SLOW_DIV - 1);
    // resolution exponent step: two to five times the code
    localparam int WTC_RES_SHIFT = 5;
    // length of the automatic calibration, in slow periods
    localparam logic [7:0] WTC_CAL_PERIODS = 8'h20;
    // second timeout in slow periods per select code
    localparam logic [5:0] WTC_SECOND_LUT [8] = '{
        6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20, 6'h30
    };
    // timer states
    typedef enum logic [3:0] {
        WTC_IDLE = 4'h1,
        WTC_FIRST = 4'h2,
        WTC_SECOND = 4'h4,
        WTC_CAL = 4'h8
    } wtc_state_t;
endpackage

// ==== core/wtc_slow_tick.sv ====
// wtc_slow_tick: divides the crystal clock down to the slow oscillator rate.
// assumes REF_CLK is the crystal clock; tick is one cycle per slow period.
`timescale 1ns/100ps
`default_nettype none
module wtc_slow_tick (
    input wire logic clk, // crystal clock
    input wire logic rst_n, // async reset, low
    input wire logic run, // oscillator powered
    output logic tick // one-cycle slow period pulse
);
    import wtc_pkg::*;
    logic [9:0] div_reg;
    // free count while powered, restart when powered down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 10'h000;
        end else if (!run || div_reg == WTC_SLOW_DIV_LAST) begin
            div_reg <= 10'h000;
        end else begin
            div_reg <= div_reg + 10'h001;
        end
    end
    // pulse on the last crystal cycle of each slow period
    assign tick = run && (div_reg == WTC_SLOW_DIV_LAST);
endmodule
`default_nettype wire

// ==== core/wtc_top.sv ====
// wtc_top: wake timer control register and its two-stage timeout timer.
// assumes a synchronous 8-bit register port; reads answer one cycle later.
// How it works
// - select codes 3 to 7 fire the second timeout 12, 16, 24, 32, 48 slow periods after the first.
// - select codes 0 to 2 fire the second timeout 4, 6, 8 slow periods after the first.
// - the timer steps every 750 crystal cycles; the second count starts at the first timeout.
// - the first timeout lasts the 16-bit count times 2^(5*resolution) slow periods.
// - writing zero to the power-down bit while it is one powers the oscillator up and, when bit 3 is also written one, starts a calibration.
// - bit 3, reset to one, enables the slow oscillator calibration.
// - bits 1:0, reset to zero, set the first timeout step to 1, 2^5, 2^10 or 2^15 periods.
// - every resolution code is accepted and honoured without restriction.
`timescale 1ns/100ps
`default_nettype none
module wtc_top (
    input wire logic REF_CLK, // crystal clock, 20 MHz
    input wire logic RST_N, // async reset, active low
    input wire logic [5:0] REG_ADDR, // register address
    input wire logic [7:0] REG_WDATA, // write data
    input wire logic REG_WR, // write strobe
    output logic [7:0] REG_RDATA, // read data, one cycle after address
    input wire logic WAKE_RUN, // periodic wake timer run request
    output logic OSC_POWERDOWN, // slow oscillator power-down
    output logic CAL_BUSY, // calibration in progress
    output logic FIRST_TIMEOUT, // first timeout pulse
    output logic SECOND_TIMEOUT // second timeout pulse
);
    import wtc_pkg::*;

    // register fields, timer state and decoded strobes
    logic [7:0] first_hi_reg;
    logic [7:0] first_lo_reg;
    logic pd_reg;
    logic [2:0] sel_reg;
    logic cal_en_reg;
    logic [1:0] res_reg;
    logic [7:0] rdata_reg;
    wtc_state_t state_reg;
    wtc_state_t state_next;
    logic [14:0] step_reg;
    logic [15:0] count_reg;
    logic [7:0] cal_reg;
    logic first_reg;
    logic second_reg;
    logic tick;
    logic wr_ctrl;
    logic cal_start;
    logic [14:0] step_last;
    logic [15:0] first_count;
    logic step_done;
    logic first_done;
    logic second_done;
    logic cal_done;

    // write decode
    assign wr_ctrl = REG_WR && (REG_ADDR == WTC_ADDR_CTRL);
    assign cal_start = wr_ctrl && !REG_WDATA[WTC_PD_BIT] && pd_reg
        && REG_WDATA[WTC_CAL_BIT];

    // first timeout count registers
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            first_hi_reg <= WTC_FIRST_HI_RST;
            first_lo_reg <= WTC_FIRST_LO_RST;
        end else if (REG_WR && REG_ADDR == WTC_ADDR_FIRST_HI) begin
            first_hi_reg <= REG_WDATA;
        end else if (REG_WR && REG_ADDR == WTC_ADDR_FIRST_LO) begin
            first_lo_reg <= REG_WDATA;
        end
    end

    // control register, reserved bit not stored
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pd_reg <= WTC_PD_RST;
            sel_reg <= WTC_SEL_RST;
            cal_en_reg <= WTC_CAL_RST;
            res_reg <= WTC_RES_RST;
        end else if (wr_ctrl) begin
            pd_reg <= REG_WDATA[WTC_PD_BIT];
            sel_reg <= REG_WDATA[WTC_SEL_HI:WTC_SEL_LO];
            cal_en_reg <= REG_WDATA[WTC_CAL_BIT];
            res_reg <= REG_WDATA[WTC_RES_HI:WTC_RES_LO];
        end
    end

    // registered read mux, unmapped reads zero
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_reg <= 8'h00;
        end else if (REG_ADDR == WTC_ADDR_FIRST_HI) begin
            rdata_reg <= first_hi_reg;
        end else if (REG_ADDR == WTC_ADDR_FIRST_LO) begin
            rdata_reg <= first_lo_reg;
        end else if (REG_ADDR == WTC_ADDR_CTRL) begin
            rdata_reg <= {pd_reg, sel_reg, cal_en_reg, 1'b0, res_reg};
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // slow oscillator period source
    wtc_slow_tick u_tick (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .run(!pd_reg),
        .tick(tick)
    );

    // step length: two to the five times resolution periods, minus one
    assign step_last = 15'((32'h1 << (WTC_RES_SHIFT * int'(res_reg))) - 1);
    assign first_count = {first_hi_reg, first_lo_reg};
    assign step_done = tick && (step_reg == step_last);
    // a zero count behaves as one step
    assign first_done = step_done && (count_reg + 16'h0001 >= first_count);
    assign second_done = tick
        && (count_reg[5:0] + 6'h01 == WTC_SECOND_LUT[sel_reg]);
    assign cal_done = tick && (cal_reg + 8'h01 == WTC_CAL_PERIODS);

    // state sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            WTC_IDLE: begin
                if (cal_start) begin
                    state_next = WTC_CAL;
                end else if (WAKE_RUN && !pd_reg) begin
                    state_next = WTC_FIRST;
                end
            end
            WTC_FIRST: begin
                if (pd_reg || !WAKE_RUN) begin
                    state_next = WTC_IDLE;
                end else if (first_done) begin
                    state_next = WTC_SECOND;
                end
            end
            WTC_SECOND: begin
                if (pd_reg || !WAKE_RUN) begin
                    state_next = WTC_IDLE;
                end else if (second_done) begin
                    state_next = WTC_FIRST;
                end
            end
            WTC_CAL: begin
                if (pd_reg || cal_done) begin
                    state_next = WTC_IDLE;
                end
            end
            default: begin
                state_next = WTC_IDLE;
            end
        endcase
    end

    // state register, calibration can start from any state
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= WTC_IDLE;
        end else if (cal_start) begin
            state_reg <= WTC_CAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // step prescaler within the first timeout
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            step_reg <= 15'h0000;
        end else if (state_reg != WTC_FIRST || step_done) begin
            step_reg <= 15'h0000;
        end else if (tick) begin
            step_reg <= step_reg + 15'h0001;
        end
    end

    // step counter for first timeout, period counter for second
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            count_reg <= 16'h0000;
        end else if (state_reg != state_next || cal_start) begin
            count_reg <= 16'h0000;
        end else if (state_reg == WTC_FIRST && step_done) begin
            count_reg <= count_reg + 16'h0001;
        end else if (state_reg == WTC_SECOND && tick) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // calibration length counter
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cal_reg <= 8'h00;
        end else if (state_reg != WTC_CAL) begin
            cal_reg <= 8'h00;
        end else if (tick) begin
            cal_reg <= cal_reg + 8'h01;
        end
    end

    // timeout pulses
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            first_reg <= 1'b0;
            second_reg <= 1'b0;
        end else begin
            first_reg <= !cal_start && state_reg == WTC_FIRST && state_next == WTC_SECOND;
            second_reg <= !cal_start && state_reg == WTC_SECOND && state_next == WTC_FIRST;
        end
    end

    // outputs straight from registers and state
    assign REG_RDATA = rdata_reg;
    assign OSC_POWERDOWN = pd_reg;
    assign CAL_BUSY = (state_reg == WTC_CAL);
    assign FIRST_TIMEOUT = first_reg;
    assign SECOND_TIMEOUT = second_reg;
endmodule
`default_nettype wire

// ==== verification/wtc_monitor.sv ====
// wtc_monitor: port assertions for the wake timer control block.
// assumes it is bound to wtc_top; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module wtc_monitor (
    input wire logic REF_CLK, // clock
    input wire logic RST_N, // reset
    input wire logic [5:0] REG_ADDR, // address
    input wire logic [7:0] REG_WDATA, // write data
    input wire logic REG_WR, // strobe
    input wire logic [7:0] REG_RDATA, // read data
    input wire logic WAKE_RUN, // run
    input wire logic OSC_POWERDOWN, // power-down
    input wire logic CAL_BUSY, // calibrating
    input wire logic FIRST_TIMEOUT, // first pulse
    input wire logic SECOND_TIMEOUT // second pulse
);
    import wtc_pkg::*;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    logic [2:0] sel_q;
    int gap_q;
    // select shadow and cycles since first timeout
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sel_q <= WTC_SEL_RST;
            gap_q <= 0;
        end else begin
            if (REG_WR && REG_ADDR == WTC_ADDR_CTRL) sel_q <= REG_WDATA[6:4];
            gap_q <= FIRST_TIMEOUT ? 1 : gap_q + 1;
        end
    end
    sequence ctrl_wr;
        REG_WR && REG_ADDR == WTC_ADDR_CTRL;
    endsequence
    sequence ctrl_rd;
        !REG_WR && REG_ADDR == WTC_ADDR_CTRL;
    endsequence
    first_pulse_a: assert property (FIRST_TIMEOUT |=> !FIRST_TIMEOUT)
        else $error("first pulse too long");
    second_pulse_a: assert property (SECOND_TIMEOUT |=> !SECOND_TIMEOUT)
        else $error("second pulse too long");
    second_gap_a: assert property (SECOND_TIMEOUT |->
        gap_q == WTC_SLOW_DIV * WTC_SECOND_LUT[sel_q])
        else $error("second timeout gap wrong");
    ctrl_read_a: assert property (ctrl_wr ##1 ctrl_rd |=>
        REG_RDATA == ($past(REG_WDATA, 2) & 8'hFB))
        else $error("control readback wrong");
    rsvd_bit_a: assert property (REG_ADDR == WTC_ADDR_CTRL |=> !REG_RDATA[2])
        else $error("reserved bit set");
    pd_write_a: assert property (ctrl_wr |=> OSC_POWERDOWN == $past(REG_WDATA[7]))
        else $error("power-down not written");
    cal_start_a: assert property (ctrl_wr ##0 (OSC_POWERDOWN && !REG_WDATA[7]
        && REG_WDATA[3]) |=> CAL_BUSY)
        else $error("calibration not started");
    cal_skip_a: assert property (ctrl_wr ##0 (!CAL_BUSY && !REG_WDATA[3]) |=> !CAL_BUSY)
        else $error("calibration while disabled");
endmodule
`default_nettype wire

// ==== verification/wtc_top_tb_top.sv ====
// wtc_top_tb_top: register and timer sequences for the wake timer control.
// assumes wtc_top and wtc_monitor are compiled first.
`timescale 1ns/100ps
`default_nettype none
module wtc_top_tb_top;
    import wtc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic run = 1'b0;
    logic [7:0] rdata;
    logic pd, cal, ev1, ev2;
    int failures = 0;
    int total_checks = 0;
    int n;
    // 20 MHz crystal clock
    always #25 clk = ~clk;
    wtc_top dut_u (.REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RDATA(rdata), .WAKE_RUN(run), .OSC_POWERDOWN(pd),
        .CAL_BUSY(cal), .FIRST_TIMEOUT(ev1), .SECOND_TIMEOUT(ev2));
    // verdict and end of run
    task automatic tally_and_finish;
        if (failures == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // one register write
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // one register read, data one cycle later
    task automatic rd_reg(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 chk(rdata, e);
    endtask
    // bounded wait: 0 first pulse, 1 second pulse, 2 calibration done
    task automatic wait_ev(input int w, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while ((w == 0 ? ev1 : w == 1 ? ev2 : !cal) !== 1'b1 && n < lim);
        if (n >= lim) begin
            failures++;
            $display("unexpected at %0t: wait %0h ran out at %0h cycles", $time, w, n);
            tally_and_finish();
        end
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(WTC_ADDR_FIRST_HI, 8'h87);
        rd_reg(WTC_ADDR_FIRST_LO, 8'h6B);
        rd_reg(WTC_ADDR_CTRL, 8'hF8);
        wr_reg(WTC_ADDR_CTRL, 8'hFF);
        rd_reg(WTC_ADDR_CTRL, 8'hFB);
        wr_reg(6'h21, 8'h55);
        rd_reg(6'h21, 8'h00);
        wr_reg(WTC_ADDR_FIRST_HI, 8'h00);
        wr_reg(WTC_ADDR_FIRST_LO, 8'h02);
        wr_reg(WTC_ADDR_CTRL, 8'h0C);
        #1 chk(cal, 1'b1);
        chk(pd, 1'b0);
        wait_ev(2, 25000);
        rd_reg(WTC_ADDR_CTRL, 8'h08);
        @(posedge clk);
        run <= 1'b1;
        wait_ev(0, 4000);
        wait_ev(1, 3100);
        chk(n, 3000);
        wait_ev(0, 3000);
        chk(32'(n >= 1499 && n <= 2250), 32'h1);
        @(posedge clk);
        run <= 1'b0;
        // power down, then power up with calibration disabled
        wr_reg(WTC_ADDR_CTRL, 8'hB1);
        wr_reg(WTC_ADDR_CTRL, 8'h31);
        wr_reg(WTC_ADDR_FIRST_LO, 8'h01);
        #1 chk(cal, 1'b0);
        rd_reg(WTC_ADDR_CTRL, 8'h31);
        @(posedge clk);
        run <= 1'b1;
        wait_ev(0, 26000);
        wait_ev(1, 9100);
        chk(n, 9000);
        wait_ev(0, 25000);
        chk(32'(n >= 23999 && n <= 24750), 32'h1);
        wr_reg(WTC_ADDR_CTRL, 8'h80);
        #1 chk(pd, 1'b1);
        tally_and_finish();
    end
endmodule
bind wtc_top wtc_monitor mon_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA), .WAKE_RUN(WAKE_RUN),
    .OSC_POWERDOWN(OSC_POWERDOWN), .CAL_BUSY(CAL_BUSY), .FIRST_TIMEOUT(FIRST_TIMEOUT),
    .SECOND_TIMEOUT(SECOND_TIMEOUT));
`default_nettype wire
